// ---- verilog/srs_status_top.sv ----
// transmit and receive status reporting, registers on AHB-Lite
// assumes transmitter and receiver event inputs are one-cycle pulses
// and line condition inputs are levels, all synchronous to i_clk_sys
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "srs_map.svh"
module srs_status_top
   import srs_pkg::*;
#(
   parameter int RXQ_DEPTH = `SRS_RXQ_DEPTH
)
(
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset_n,
   // ahb-lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   // channel mode
   input  wire logic        i_sync_mode,
   input  wire logic        i_hdlc_mode,
   input  wire logic        i_async_mode,
   // transmitter events and state
   input  wire logic        i_tx_preamble_done,
   input  wire logic        i_tx_idle_unit_done,
   input  wire logic        i_tx_idle_is_pattern,
   input  wire logic        i_tx_idle_active,
   input  wire logic        i_tx_abort_done,
   input  wire logic        i_tx_frame_end_done,
   input  wire logic        i_tx_check_done,
   input  wire logic        i_tx_shifting,
   input  wire logic        i_tx_needs_char,
   input  wire logic        i_tx_queue_empty,
   // receiver characters and line conditions
   input  wire logic        i_rx_push,
   input  wire logic [7:0]  i_rx_char,
   input  wire logic [4:0]  i_rx_mark,
   input  wire logic        i_line_idle_detected,
   input  wire logic        i_line_idle_active,
   input  wire logic        i_break_abort_event,
   input  wire logic        i_break_active,
   // status outputs
   output logic             o_tx_int_req,
   output logic             o_rx_int_req,
   output logic             o_rx_status_pending,
   output logic             o_rx_full,
   output logic             o_paired_char_status_select,
   output logic      [2:0]  o_tx_idle_mode
);

   ////////////////////////////////////////////////////////////////////////
   // bus slave: zero wait states, reads sampled in the address phase
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [31:0] hrdata_q;

   wire       bus_take = i_hsel & i_htrans[1] & i_hready;
   wire       hi_zero  = (i_haddr[31:8] == 24'h000000);
   wire [7:0] a_ofs    = hi_zero ? i_haddr[7:0] : `SRS_OFS_NONE;
   wire       rd_take  = bus_take & ~i_hwrite;
   wire       rd_tcs   = rd_take & (a_ofs == `SRS_OFS_TX_CMD_STAT);
   wire       rd_tic   = rd_take & (a_ofs == `SRS_OFS_TX_INT_CTRL);
   wire       rd_rcs   = rd_take & (a_ofs == `SRS_OFS_RX_CMD_STAT);
   wire       rd_ric   = rd_take & (a_ofs == `SRS_OFS_RX_INT_CTRL);
   wire       rd_dat   = rd_take & (a_ofs == `SRS_OFS_RX_DATA);
   wire       wr_tcs   = wr_pend_q & (wr_addr_q == `SRS_OFS_TX_CMD_STAT);
   wire       wr_tic   = wr_pend_q & (wr_addr_q == `SRS_OFS_TX_INT_CTRL);
   wire       wr_rcs   = wr_pend_q & (wr_addr_q == `SRS_OFS_RX_CMD_STAT);
   wire       wr_ric   = wr_pend_q & (wr_addr_q == `SRS_OFS_RX_INT_CTRL);

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= `SRS_OFS_NONE;
      end
      else
      begin
         wr_pend_q <= bus_take & i_hwrite;
         wr_addr_q <= a_ofs;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers
   logic [7:0] tx_arm_q;
   logic [7:0] rx_arm_q;
   logic [2:0] idle_mode_q;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         tx_arm_q    <= `SRS_RST_ARM;
         rx_arm_q    <= `SRS_RST_ARM;
         idle_mode_q <= `SRS_RST_IDLE_MODE;
      end
      else
      begin
         if (wr_tic)
            tx_arm_q <= i_hwdata[7:0];
         if (wr_ric)
            rx_arm_q <= i_hwdata[7:0];
         if (wr_tcs)
            idle_mode_q <= i_hwdata[`SRS_TX_IDLE_MODE_LSB +: 3];
      end
   end

   wire paired = rx_arm_q[`SRS_RIC_PAIRED];

   ////////////////////////////////////////////////////////////////////////
   // transmit flags
   logic [7:0] tx_flag_q;
   logic       idle_once_q;
   logic       tx_req_q;
   wire  [7:0] tx_set;

   // a non-pattern idle gives one flag per idle stretch
   wire idle_set = i_tx_idle_unit_done &
                   (i_tx_idle_is_pattern | ~idle_once_q);

   assign tx_set[`SRS_TX_PREAMBLE]  = i_tx_preamble_done & i_sync_mode;
   assign tx_set[`SRS_TX_IDLE_UNIT] = idle_set;
   assign tx_set[`SRS_TX_ABORT]     = i_tx_abort_done & i_hdlc_mode;
   assign tx_set[`SRS_TX_FRAME_END] = i_tx_frame_end_done & i_sync_mode;
   assign tx_set[`SRS_TX_CHECK_SEQ] = i_tx_check_done & i_sync_mode;
   assign tx_set[`SRS_TX_SHIFTER]   = 1'b0;
   // transmitter raises needs_char early enough for the starved lead
   assign tx_set[`SRS_TX_STARVED]   = i_tx_needs_char &
                                      i_tx_queue_empty;
   assign tx_set[`SRS_TX_VACANT]    = 1'b0;

   wire [7:0] tx_clr    = wr_tcs ? (i_hwdata[7:0] & `SRS_TX_W1C_MASK)
                                 : 8'h00;
   // set wins over a clear landing in the same cycle
   wire [7:0] tx_flag_d = (tx_set | (tx_flag_q & ~tx_clr))
                          & `SRS_TX_W1C_MASK;
   wire       tx_rise   = |(tx_set & ~tx_flag_q & tx_arm_q);
   wire [7:0] tx_view;

   assign tx_view = {tx_flag_q[7:3],
                     ~i_tx_shifting,
                     tx_flag_q[`SRS_TX_STARVED],
                     i_tx_queue_empty};

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         tx_flag_q   <= `SRS_RST_TX_FLAGS;
         idle_once_q <= 1'b0;
         tx_req_q    <= 1'b0;
      end
      else
      begin
         tx_flag_q   <= tx_flag_d;
         idle_once_q <= i_tx_idle_active & (idle_once_q | idle_set);
         tx_req_q    <= tx_rise;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // receive queue
   srs_rxq_if #(.DEPTH(RXQ_DEPTH)) rxq ();

   srs_rx_queue #(.DEPTH(RXQ_DEPTH)) u_rxq
   (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .q         (rxq.store)
   );

   wire nonempty = (rxq.count != '0);
   wire two_plus = (rxq.count > 1);
   wire use_two  = paired & two_plus;

   assign rxq.push       = i_rx_push;
   assign rxq.wdata      = {i_rx_mark,
                            i_rx_char};
   assign rxq.pop        = rd_dat & nonempty;
   assign rxq.pop2       = rd_dat & use_two;

   // marks of the oldest one or two entries, also what a read returns
   wire srs_mark_t head_mark = use_two ? (rxq.head0.mark | rxq.head1.mark)
                                       : rxq.head0.mark;
   wire [2:0] head3  = {head_mark[`SRS_MK_BOUND],
                        head_mark[`SRS_MK_ABORT],
                        head_mark[`SRS_MK_OVER]} & {3{nonempty}};
   wire [2:0] rx_arm3 = {rx_arm_q[`SRS_RX_BOUNDARY],
                         rx_arm_q[`SRS_RX_ABORT_PARITY],
                         rx_arm_q[`SRS_RX_OVERFLOW]};

   ////////////////////////////////////////////////////////////////////////
   // queued receive status
   logic [2:0] rx_latch_q;
   logic       rx_ip_q;
   logic       hold_v_q;
   srs_mark_t  hold_mark_q;

   wire [2:0] rx_clr3 = wr_rcs ? {i_hwdata[`SRS_RX_BOUNDARY],
                                  i_hwdata[`SRS_RX_ABORT_PARITY],
                                  i_hwdata[`SRS_RX_OVERFLOW]} : 3'h0;
   wire [2:0] rx_latch_d = (head3 & rx_arm3) |
                           (rx_latch_q & ~rx_clr3);
   wire       ip_set  = rxq.pop & |(head3 & rx_arm3);
   wire       ip_clr  = |rx_clr3;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         rx_latch_q  <= 3'h0;
         rx_ip_q     <= 1'b0;
         hold_v_q    <= 1'b0;
         hold_mark_q <= '0;
      end
      else
      begin
         rx_latch_q <= rx_latch_d;
         rx_ip_q    <= ip_set | (rx_ip_q & ~ip_clr);
         if (rd_dat)
         begin
            hold_v_q    <= nonempty & head_mark[`SRS_MK_BOUND];
            hold_mark_q <= head_mark;
         end
         else if (rd_rcs)
            hold_v_q <= 1'b0;
      end
   end

   // unarmed view: held boundary marks, else the queue head
   wire srs_mark_t unarmed = hold_v_q ? hold_mark_q
                             : (head_mark & {5{nonempty}});
   wire v_bound = rx_arm3[2] ? rx_latch_q[2] : unarmed[`SRS_MK_BOUND];
   wire v_abort = rx_arm3[1] ? rx_latch_q[1] : unarmed[`SRS_MK_ABORT];
   wire v_over  = rx_arm3[0] ? rx_latch_q[0] : unarmed[`SRS_MK_OVER];

   ////////////////////////////////////////////////////////////////////////
   // line condition flags: idle detected and break or abort
   logic [1:0] line_flag_q;
   logic [1:0] unlatch_q;
   logic       rx_req_q;
   wire  [1:0] line_set = {i_line_idle_detected, i_break_abort_event};
   wire  [1:0] line_wr  = wr_rcs ? {i_hwdata[`SRS_RX_LINE_IDLE],
                                    i_hwdata[`SRS_RX_BREAK_ABORT]}
                                 : 2'b00;
   // abort sense clears at once; idle and break wait for the line
   wire  [1:0] cond_on  = {i_line_idle_active,
                           i_async_mode & i_break_active};
   wire  [1:0] line_arm = {rx_arm_q[`SRS_RX_LINE_IDLE],
                           rx_arm_q[`SRS_RX_BREAK_ABORT]};
   wire  [1:0] line_d;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_line
         wire want_clr = unlatch_q[gi] | line_wr[gi];
         assign line_d[gi] = line_set[gi] |
                             (line_flag_q[gi] &
                              ~(want_clr & ~cond_on[gi]));

         always_ff @(posedge i_clk_sys)
         begin
            if (!i_reset_n)
            begin
               line_flag_q[gi] <= 1'b0;
               unlatch_q[gi]   <= 1'b0;
            end
            else
            begin
               line_flag_q[gi] <= line_d[gi];
               unlatch_q[gi]   <= line_d[gi] & want_clr & ~line_set[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
         rx_req_q <= 1'b0;
      else
         rx_req_q <= |(line_set & ~line_flag_q & line_arm);
   end

   ////////////////////////////////////////////////////////////////////////
   // read data
   wire [15:0] rx_view = {7'h00, unarmed[`SRS_MK_SHORT], 1'b0,
                          line_flag_q[1], line_flag_q[0], v_bound,
                          unarmed[`SRS_MK_CHECK], v_abort, v_over,
                          nonempty};
   wire [15:0] dat_view = {use_two ? rxq.head1.ch : 8'h00,
                           nonempty ? rxq.head0.ch : 8'h00};
   wire [31:0] rd_word =
      rd_tcs ? {21'h000000, idle_mode_q, tx_view} :
      rd_tic ? {24'h000000, tx_arm_q} :
      rd_rcs ? {16'h0000, rx_view} :
      rd_ric ? {24'h000000, rx_arm_q} :
      rd_dat ? {16'h0000, dat_view} : 32'h00000000;

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
         hrdata_q <= 32'h00000000;
      else if (rd_take)
         hrdata_q <= rd_word;
   end

   assign o_hrdata                    = hrdata_q;
   assign o_hreadyout                 = 1'b1;
   assign o_hresp                     = 1'b0;
   assign o_tx_int_req                = tx_req_q;
   assign o_rx_int_req                = rx_req_q;
   assign o_rx_status_pending         = rx_ip_q;
   assign o_rx_full                   = rxq.full;
   assign o_paired_char_status_select = paired;
   assign o_tx_idle_mode              = idle_mode_q;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);

   sequence s_tx_flag_kept;
      tx_flag_q[`SRS_TX_STARVED] && !tx_clr[`SRS_TX_STARVED];
   endsequence

   sequence s_armed_read;
      rxq.pop && |(head3 & rx_arm3);
   endsequence

   a_flag_sticky_hold: assert property (
      s_tx_flag_kept |=> tx_flag_q[`SRS_TX_STARVED])
      else $error("starved flag dropped without a write of one");

   a_zero_write_kept: assert property (
      (wr_tcs && !i_hwdata[`SRS_TX_PREAMBLE] && tx_flag_q[`SRS_TX_PREAMBLE])
      |=> tx_flag_q[`SRS_TX_PREAMBLE])
      else $error("write of zero cleared the preamble flag");

   a_tx_req_rise: assert property (
      o_tx_int_req |-> |(tx_flag_q & ~$past(tx_flag_q) & $past(tx_arm_q)))
      else $error("transmit request without an armed rising flag");

   a_preamble_mode: assert property (
      (!i_sync_mode && !tx_flag_q[`SRS_TX_PREAMBLE]
       && !i_tx_idle_unit_done) |=> !tx_flag_q[`SRS_TX_PREAMBLE])
      else $error("preamble flag set outside sync modes");

   a_abort_mode: assert property (
      (i_tx_abort_done && i_hdlc_mode) |=> tx_flag_q[`SRS_TX_ABORT])
      else $error("abort flag missed in bit-oriented mode");

   a_vacant_read: assert property (
      rd_tcs |=> o_hrdata[`SRS_TX_VACANT] == $past(i_tx_queue_empty))
      else $error("vacant bit does not follow the transmit queue");

   a_drained_read: assert property (
      (rd_tcs && i_tx_shifting) |=> !o_hrdata[`SRS_TX_SHIFTER])
      else $error("shifter drained read as one while shifting");

   a_idle_wait_line: assert property (
      (line_flag_q[1] && i_line_idle_active) |=> line_flag_q[1])
      else $error("idle flag cleared while the line is still idle");

   a_pending_on_read: assert property (
      s_armed_read |=> rx_ip_q ##1 (rx_ip_q || $past(ip_clr)))
      else $error("status pending not raised by the data read");

   a_armed_latch: assert property (
      (rx_arm3[2] && head3[2]) |=> rx_latch_q[2])
      else $error("armed boundary mark not latched at the head");

   a_hold_boundary: assert property (
      (rd_dat && nonempty && head_mark[`SRS_MK_BOUND]) ##1 !rd_rcs
      |-> hold_v_q)
      else $error("boundary character status not held after read");

endmodule // srs_status_top

// ---- verilog/srs_map.svh ----
// register offsets, bit positions and reset values of the status block
// assumes byte addresses on a 32-bit AHB-Lite bus, one register per word
`ifndef SRS_MAP_SVH
`define SRS_MAP_SVH

// register byte offsets
`define SRS_OFS_TX_CMD_STAT   8'h00
`define SRS_OFS_TX_INT_CTRL   8'h04
`define SRS_OFS_RX_CMD_STAT   8'h08
`define SRS_OFS_RX_INT_CTRL   8'h0c
`define SRS_OFS_RX_DATA       8'h10
`define SRS_OFS_NONE          8'hff

// transmit_command_status low byte and idle mode field
`define SRS_TX_PREAMBLE       7
`define SRS_TX_IDLE_UNIT      6
`define SRS_TX_ABORT          5
`define SRS_TX_FRAME_END      4
`define SRS_TX_CHECK_SEQ      3
`define SRS_TX_SHIFTER        2
`define SRS_TX_STARVED        1
`define SRS_TX_VACANT         0
`define SRS_TX_W1C_MASK       8'hfa
`define SRS_TX_IDLE_MODE_LSB  8

// receive_command_status bits
`define SRS_RX_SHORT_FRAME    8
`define SRS_RX_LINE_IDLE      6
`define SRS_RX_BREAK_ABORT    5
`define SRS_RX_BOUNDARY       4
`define SRS_RX_CHECK_ERR      3
`define SRS_RX_ABORT_PARITY   2
`define SRS_RX_OVERFLOW       1
`define SRS_RX_AVAIL          0

// receive_interrupt_control word status bit
`define SRS_RIC_PAIRED        3

// position of each mark inside a queued entry
`define SRS_MK_SHORT          4
`define SRS_MK_BOUND          3
`define SRS_MK_CHECK          2
`define SRS_MK_ABORT          1
`define SRS_MK_OVER           0

// reset values and default receive queue depth
`define SRS_RST_TX_FLAGS      8'h00
`define SRS_RST_ARM           8'h00
`define SRS_RST_IDLE_MODE     3'h0
`define SRS_RXQ_DEPTH         32

`endif

// ---- verilog/srs_pkg.sv ----
// types shared by the status block and its receive queue
// assumes srs_map.svh supplies the numeric constants
package srs_pkg;

   typedef logic [4:0] srs_mark_t;

   typedef struct packed
   {
      srs_mark_t  mark;
      logic [7:0] ch;
   } srs_entry_t;

endpackage

// ---- verilog/srs_rxq_if.sv ----
// carrier between the status logic and its receive queue
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface srs_rxq_if
   import srs_pkg::*;
#(
   parameter int DEPTH = 32
);
   localparam int CW = $clog2(DEPTH + 1);

   logic          push;
   srs_entry_t    wdata;
   logic          pop;
   logic          pop2;
   srs_entry_t    head0;
   srs_entry_t    head1;
   logic [CW-1:0] count;
   logic          full;

   modport store (input push, wdata, pop, pop2,
                  output head0, head1, count, full);
   modport user  (output push, wdata, pop, pop2,
                  input head0, head1, count, full);
endinterface

// ---- verilog/srs_rx_queue.sv ----
// receive queue: each character travels with its five status marks
// assumes the user never pops more entries than count shows
`timescale 1ns/1ps
module srs_rx_queue
   import srs_pkg::*;
#(
   parameter int DEPTH = 32
)
(
   // clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_reset_n,
   // queue port
   srs_rxq_if.store  q
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   srs_entry_t    mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [CW-1:0] cnt_q;

   wire           do_push = q.push & ~q.full;
   wire [CW-1:0]  n_pop   = q.pop ? (q.pop2 ? CW'(2) : CW'(1)) : '0;

   ////////////////////////////////////////////////////////////////////////
   // storage has no reset: contents are meaningless until counted in
   always_ff @(posedge i_clk_sys)
   begin
      if (do_push)
         mem[wr_q] <= q.wdata;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (!i_reset_n)
      begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wr_q  <= wr_q + AW'(do_push);
         rd_q  <= rd_q + AW'(n_pop);
         cnt_q <= cnt_q + CW'(do_push) - n_pop;
      end
   end

   assign q.head0 = mem[rd_q];
   assign q.head1 = mem[rd_q + AW'(1)];
   assign q.count = cnt_q;
   assign q.full  = (cnt_q == CW'(DEPTH));

   ////////////////////////////////////////////////////////////////////////
   a_mark_carried: assert property (@(posedge i_clk_sys)
      disable iff (!i_reset_n)
      (do_push && cnt_q == '0 && !q.pop) |=> q.head0 == $past(q.wdata))
      else $error("queued marks lost on the way through the queue");

endmodule // srs_rx_queue

// ---- tb/srs_host_model.sv ----
// host side: single-word AHB-Lite master for the bench
// assumes each task is entered just after a rising clock edge
`timescale 1ns/1ps
module srs_host_model
(
   // clock and slave answer
   input  wire logic        i_clk_sys,
   input  wire logic        i_hready,
   input  wire logic [31:0] i_hrdata,
   // request
   output logic             o_hsel,
   output logic      [31:0] o_haddr,
   output logic      [1:0]  o_htrans,
   output logic             o_hwrite,
   output logic      [2:0]  o_hsize,
   output logic      [31:0] o_hwdata
);
   ////////////////////////////////////////
   initial
   begin
      {o_hsel, o_haddr, o_htrans, o_hwrite, o_hwdata} = '0;
      o_hsize = 3'h2;
   end

   // phases are held until hready is seen high; no latency is assumed
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
      o_hsel   <= 1'b1;
      o_haddr  <= {24'h0, a};
      o_htrans <= 2'h2;
      o_hwrite <= wr;
      @(posedge i_clk_sys);
      while (i_hready !== 1'b1)
         @(posedge i_clk_sys);
      o_htrans <= 2'h0;
      o_hwdata <= wd;
      @(posedge i_clk_sys);
      while (i_hready !== 1'b1)
         @(posedge i_clk_sys);
      rd = i_hrdata;
   endtask
endmodule // srs_host_model

// ---- tb/testbench.sv ----
// self-checking bench for the status block
// assumes the host model owns the bus and the bench drives all events
`timescale 1ns/1ps
`include "srs_map.svh"
module testbench
   import srs_pkg::*;
   ;
   typedef struct packed {logic [2:0] m; logic [5:0] e; logic [7:0] f;}
      srs_row_t;
   logic        i_clk_sys = 1'b0;
   logic        i_reset_n;
   logic        i_hsel, i_hwrite, i_hready, o_hreadyout, o_hresp;
   logic [31:0] i_haddr, i_hwdata, o_hrdata, rd;
   logic [1:0]  i_htrans;
   logic [2:0]  i_hsize, o_tx_idle_mode;
   logic [5:0]  ev;
   logic        i_sync_mode, i_hdlc_mode, i_async_mode;
   logic        i_tx_preamble_done, i_tx_idle_unit_done, i_tx_abort_done;
   logic        i_tx_frame_end_done, i_tx_check_done, i_tx_needs_char;
   logic        i_tx_idle_is_pattern, i_tx_idle_active, i_tx_shifting;
   logic        i_tx_queue_empty, i_rx_push, i_line_idle_detected;
   logic        i_line_idle_active, i_break_abort_event, i_break_active;
   logic [7:0]  i_rx_char;
   srs_mark_t   i_rx_mark;
   logic        o_tx_int_req, o_rx_int_req, o_rx_status_pending;
   logic        o_rx_full, o_paired_char_status_select;
   int          err_total = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          tx_ints = 0;
   int          rx_ints = 0;
   // mode {sync,hdlc,async}, event pulse, flag expected in the low byte
   srs_row_t rows [6] = '{'{3'h4, 6'h20, 8'h80}, '{3'h4, 6'h10, 8'h40},
      '{3'h6, 6'h08, 8'h20}, '{3'h4, 6'h04, 8'h10},
      '{3'h4, 6'h02, 8'h08}, '{3'h1, 6'h01, 8'h02}};

   assign i_hready = o_hreadyout;
   assign {i_tx_preamble_done, i_tx_idle_unit_done, i_tx_abort_done,
           i_tx_frame_end_done, i_tx_check_done, i_tx_needs_char} = ev;

   srs_status_top #(.RXQ_DEPTH(32)) dut (.*);
   srs_host_model host (.i_clk_sys, .i_hready(o_hreadyout),
      .i_hrdata(o_hrdata), .o_hsel(i_hsel), .o_haddr(i_haddr),
      .o_htrans(i_htrans), .o_hwrite(i_hwrite), .o_hsize(i_hsize),
      .o_hwdata(i_hwdata));

   ////////////////////////////////////////
   always #50 i_clk_sys = ~i_clk_sys;

   always @(posedge i_clk_sys)
   begin
      cyc <= cyc + 1;
      tx_ints <= tx_ints + int'(o_tx_int_req === 1'b1);
      rx_ints <= rx_ints + int'(o_rx_int_req === 1'b1);
      if (cyc == 4000)
      begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, rd);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
      host.xfer(1'b0, a, 32'h0, rd);
      check(nm, rd, e);
   endtask

   task automatic pulse(input logic [5:0] e);
      ev <= e;
      tick(1);
      ev <= 6'h00;
      tick(2);
   endtask

   // the trailing idle edge keeps back-to-back pushes apart
   task automatic push(input logic [7:0] c, input srs_mark_t m);
      i_rx_push <= 1'b1;
      i_rx_char <= c;
      i_rx_mark <= m;
      tick(1);
      i_rx_push <= 1'b0;
      tick(1);
   endtask

   ////////////////////////////////////////
   initial
   begin
      i_reset_n = 1'b0;
      ev = 6'h00;
      {i_sync_mode, i_hdlc_mode, i_async_mode, i_tx_idle_is_pattern,
       i_tx_idle_active, i_tx_shifting, i_rx_push, i_line_idle_detected,
       i_line_idle_active, i_break_abort_event, i_break_active} = '0;
      {i_rx_char, i_rx_mark} = '0;
      i_tx_queue_empty = 1'b1;
      tick(2);
      i_reset_n <= 1'b1;
      tick(1);
      rdc("tcs rst", 8'h00, 32'h5);
      rdc("tic rst", 8'h04, 32'h0);
      wr(8'h04, 32'hff);
      foreach (rows[k])
      begin
         {i_sync_mode, i_hdlc_mode, i_async_mode} <= rows[k].m;
         pulse(rows[k].e);
         rdc("flag", 8'h00, {24'h0, rows[k].f | 8'h05});
         check("one req", tx_ints, k + 1);
         pulse(rows[k].e);
         check("no repeat", tx_ints, k + 1);
         wr(8'h00, 32'h0);
         rdc("w0 kept", 8'h00, {24'h0, rows[k].f | 8'h05});
         wr(8'h00, {24'h0, rows[k].f});
         rdc("w1 clr", 8'h00, 32'h5);
      end
      wr(8'h04, 32'h0);
      {i_sync_mode, i_hdlc_mode, i_async_mode} <= 3'h4;
      pulse(6'h20);
      rdc("unarmed", 8'h00, 32'h85);
      check("no req", tx_ints, 6);
      {i_sync_mode, i_hdlc_mode, i_async_mode} <= 3'h1;
      i_tx_shifting <= 1'b1;
      i_tx_queue_empty <= 1'b0;
      wr(8'h00, 32'h7ff);
      rdc("ro bits", 8'h00, 32'h700);
      check("idle mode", o_tx_idle_mode, 3'h7);
      i_tx_shifting <= 1'b0;
      i_tx_queue_empty <= 1'b1;
      rdc("unmapped", 8'h40, 32'h0);
      check("resp", o_hresp, 0);
      i_tx_idle_active <= 1'b1;
      pulse(6'h10);
      wr(8'h00, 32'h40);
      pulse(6'h10);
      rdc("idle once", 8'h00, 32'h5);
      i_tx_idle_is_pattern <= 1'b1;
      pulse(6'h10);
      rdc("idle again", 8'h00, 32'h45);
      push(8'h11, 5'h04);
      push(8'h22, 5'h08);
      rdc("rx head", 8'h08, 32'h9);
      wr(8'h0c, 32'h8);
      rdc("rx pair", 8'h08, 32'h19);
      check("wsel", o_paired_char_status_select, 1);
      wr(8'h0c, 32'h0);
      rdc("rx a", 8'h10, 32'h11);
      rdc("rx b", 8'h10, 32'h22);
      rdc("rx held", 8'h08, 32'h10);
      wr(8'h0c, 32'h50);
      push(8'h33, 5'h08);
      tick(2);
      rdc("armed", 8'h08, 32'h11);
      check("pend early", o_rx_status_pending, 0);
      rdc("rx c", 8'h10, 32'h33);
      tick(1);
      check("pend", o_rx_status_pending, 1);
      wr(8'h08, 32'h10);
      tick(1);
      check("pend clr", o_rx_status_pending, 0);
      rdc("rx clr", 8'h08, 32'h0);
      i_line_idle_active <= 1'b1;
      i_line_idle_detected <= 1'b1;
      tick(1);
      i_line_idle_detected <= 1'b0;
      tick(2);
      wr(8'h08, 32'h40);
      rdc("idle on", 8'h08, 32'h40);
      i_line_idle_active <= 1'b0;
      tick(2);
      rdc("idle off", 8'h08, 32'h0);
      check("rx req", rx_ints, 1);
      i_break_active <= 1'b1;
      i_break_abort_event <= 1'b1;
      tick(1);
      i_break_abort_event <= 1'b0;
      wr(8'h08, 32'h20);
      rdc("brk on", 8'h08, 32'h20);
      i_break_active <= 1'b0;
      tick(2);
      rdc("brk off", 8'h08, 32'h0);
      check("brk no req", rx_ints, 1);
      repeat (31) push(8'h44, 5'h00);
      check("rx not full", o_rx_full, 0);
      push(8'h44, 5'h00);
      check("rx full", o_rx_full, 1);
      i_reset_n <= 1'b0;
      tick(2);
      i_reset_n <= 1'b1;
      tick(1);
      check("full rst", o_rx_full, 0);
      rdc("tcs rst2", 8'h00, 32'h5);
      rdc("rcs rst2", 8'h08, 32'h0);
      report_and_stop();
   end
endmodule // testbench
